/* File: rtl/mac_pause_flow_control.sv */
// Receive FIFO and the pause flow-control block of an Ethernet MAC.
// Assumes a receiver that delivers frame bytes in order, a transmitter that
// honours the halt and pause-request handshakes, and one AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none

module rx_fifo #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic      [WIDTH-1:0] out_data,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             nfull_q;
    logic             nempty_q;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("rx_fifo depth must be a power of two of at least 2");
    end

    assign push      = in_valid && nfull_q;
    assign pop       = out_ready && nempty_q;
    assign in_ready  = nfull_q;
    assign out_valid = nempty_q;
    assign out_data  = mem_q[rp_q];
    assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always_ff @(posedge clk) begin
        if (rst) begin
            wp_q     <= '0;
            rp_q     <= '0;
            cnt_q    <= '0;
            nfull_q  <= 1'b1;
            nempty_q <= 1'b0;
        end else begin
            wp_q     <= wp_q + AW'(push);
            rp_q     <= rp_q + AW'(pop);
            cnt_q    <= cnt_d;
            nfull_q  <= cnt_d != (AW+1)'(DEPTH);
            nempty_q <= cnt_d != '0;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end
endmodule

module mac_pause_flow_control import mac_pause_pkg::*; #(
    parameter int unsigned SLOT_CYCLES_10M = SLOT_CYC_10,
    parameter int unsigned FIFO_DEPTH      = RX_FIFO_DEPTH
) (
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic             HREADYOUT,
    output logic      [31:0] HRDATA,
    output logic             HRESP,
    input  wire logic        RX_IN_VALID,
    input  wire logic [7:0]  RX_IN_DATA,
    input  wire logic        RX_IN_LAST,
    input  wire logic        RX_IN_ERR,
    output logic             RX_IN_READY,
    output logic             RX_OUT_VALID,
    output logic      [7:0]  RX_OUT_DATA,
    output logic             RX_OUT_LAST,
    output logic             RX_OUT_ERR,
    output logic             RX_OUT_FILTER,
    input  wire logic        RX_OUT_READY,
    output logic             TX_HALT,
    output logic             TX_PAUSE_REQ,
    output logic      [15:0] TX_PAUSE_TIME,
    input  wire logic        TX_PAUSE_DONE,
    output logic             BACKPRESSURE
);
    logic [15:0] time_q;
    logic        pass_q;
    logic        pause_decode_enable_q;
    logic        fd_q;
    logic        txen_q;
    logic        promisc_q;
    logic        spd_q;
    logic        send_q;
    logic        busy_q;
    logic        wr_pend_q;
    logic [7:0]  wr_idx_q;
    logic        wr_cfg;
    logic [4:0]  pos_q;
    logic        match_q;
    logic [7:0]  thi_q;
    logic [7:0]  tlo_q;
    logic [15:0] rx_time;
    logic [8:0]  exp_cur;
    logic        byte_ok;
    logic        push;
    logic        pause_hit;
    logic        pause_load;
    logic [15:0] quanta_q;
    logic [15:0] quanta_d;
    logic [12:0] slot_q;
    logic [12:0] slot_max;
    logic        rx_ready;
    fc_state_e   state_q;
    fc_state_e   state_d;
    rx_beat_s    in_beat;
    rx_beat_s    out_beat;

    if (SLOT_CYCLES_10M < 1 || SLOT_CYCLES_10M > 8192) begin : g_chk
        $error("SLOT_CYCLES_10M must lie in 1..8192");
    end

    // Expected frame byte at a position, with a care bit on top.
    function automatic logic [8:0] exp_byte(input logic [4:0] i);
        logic [31:0] type_op;
        type_op = {PAUSE_ETYPE, PAUSE_OPCODE};
        if (i < 5'd6) begin
            return {1'b1, PAUSE_DA[8*(5-int'(i)) +: 8]};
        end else if (i >= POS_TYPE && i < POS_TIME) begin
            return {1'b1, type_op[8*(15-int'(i)) +: 8]};
        end
        return 9'h000;
    endfunction

    function automatic logic [31:0] rd_word(input logic [7:0] idx);
        unique case (idx)
            IDX_PAUSE_CTRL: return {time_q, 13'h0000, pass_q, pause_decode_enable_q, busy_q};
            IDX_MAC_CFG:    return {27'h0000000, send_q, spd_q, promisc_q, txen_q, fd_q};
            IDX_MAC_STAT:   return {14'h0000, BACKPRESSURE, TX_HALT, quanta_q};
            default:        return 32'h0000_0000;
        endcase
    endfunction

    // Bus slave: zero wait states, always OKAY, unmapped words read zero.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
            HRDATA    <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            wr_pend_q <= HSEL && HTRANS[1] && HWRITE && HREADY && HADDR[31:10] == '0;
            wr_idx_q  <= HADDR[9:2];
            HRDATA    <= (HSEL && HTRANS[1] && !HWRITE && HREADY && HADDR[31:10] == '0) ?
                         rd_word(HADDR[9:2]) : 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end
    end

    assign wr_cfg = wr_pend_q && wr_idx_q == IDX_MAC_CFG;

    // The busy position of a write is ignored; busy is hardware state.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            time_q <= PAUSE_CTRL_RST[PC_TIME_LSB +: 16];
            pass_q <= PAUSE_CTRL_RST[PC_PASS_BIT];
            pause_decode_enable_q <= PAUSE_CTRL_RST[PC_EN_BIT];
        end else if (wr_pend_q && wr_idx_q == IDX_PAUSE_CTRL) begin
            time_q <= HWDATA[PC_TIME_LSB +: 16];
            pass_q <= HWDATA[PC_PASS_BIT];
            pause_decode_enable_q <= HWDATA[PC_EN_BIT];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            fd_q      <= MAC_CFG_RST[CFG_FD_BIT];
            txen_q    <= MAC_CFG_RST[CFG_TXEN_BIT];
            promisc_q <= MAC_CFG_RST[CFG_PROMISC_BIT];
            spd_q     <= MAC_CFG_RST[CFG_SPEED100_BIT];
        end else if (wr_cfg) begin
            fd_q      <= HWDATA[CFG_FD_BIT];
            txen_q    <= HWDATA[CFG_TXEN_BIT];
            promisc_q <= HWDATA[CFG_PROMISC_BIT];
            spd_q     <= HWDATA[CFG_SPEED100_BIT];
        end
    end

    // A software write in the same cycle as the completion wins.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            send_q <= MAC_CFG_RST[CFG_SEND_BIT];
        end else if (wr_cfg) begin
            send_q <= HWDATA[CFG_SEND_BIT];
        end else if (state_q == FC_SEND && TX_PAUSE_DONE) begin
            send_q <= 1'b0;
        end
    end

    // Receive parser: runs on every accepted byte, decodes only when enabled.
    assign push    = RX_IN_VALID && rx_ready;
    assign exp_cur = exp_byte(pos_q);
    assign byte_ok = !exp_cur[8] || exp_cur[7:0] == RX_IN_DATA;
    assign rx_time = {thi_q, tlo_q};
    assign pause_hit = push && RX_IN_LAST && !RX_IN_ERR && pause_decode_enable_q && match_q && byte_ok &&
                       pos_q >= POS_MIN_LAST;
    assign pause_load = pause_hit && fd_q;

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pos_q   <= 5'h00;
            match_q <= 1'b1;
            thi_q   <= 8'h00;
            tlo_q   <= 8'h00;
        end else if (push) begin
            pos_q   <= RX_IN_LAST ? 5'h00 : (pos_q == 5'h1f ? pos_q : pos_q + 5'h01);
            match_q <= RX_IN_LAST ? 1'b1 : match_q && byte_ok;
            if (pos_q == POS_TIME) begin
                thi_q <= RX_IN_DATA;
            end
            if (pos_q == POS_TIME + 5'h01) begin
                tlo_q <= RX_IN_DATA;
            end
        end
    end

    // Every byte goes into the FIFO whatever its status; the filter flag rides on the last.
    always_comb begin
        in_beat.data = RX_IN_DATA;
        in_beat.last = RX_IN_LAST;
        in_beat.err  = RX_IN_ERR;
        in_beat.filt = pause_hit && pass_q && !promisc_q;
    end

    rx_fifo #(
        .WIDTH ($bits(rx_beat_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK),
        .rst       (RST),
        .in_valid  (RX_IN_VALID),
        .in_data   (in_beat),
        .in_ready  (rx_ready),
        .out_valid (RX_OUT_VALID),
        .out_data  (out_beat),
        .out_ready (RX_OUT_READY)
    );

    assign RX_IN_READY   = rx_ready;
    assign RX_OUT_DATA   = out_beat.data;
    assign RX_OUT_LAST   = out_beat.last;
    assign RX_OUT_ERR    = out_beat.err;
    assign RX_OUT_FILTER = out_beat.filt;

    // Pause countdown in slots of 512 bit times at the current speed.
    assign slot_max = spd_q ? 13'(SLOT_CYC_100 - 1) : 13'(SLOT_CYCLES_10M - 1);

    always_comb begin
        quanta_d = quanta_q;
        if (pause_load) begin
            quanta_d = rx_time;
        end else if (quanta_q != 16'h0000 && slot_q == slot_max) begin
            quanta_d = quanta_q - 16'h0001;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            quanta_q <= 16'h0000;
            slot_q   <= 13'h0000;
            TX_HALT  <= 1'b0;
        end else begin
            quanta_q <= quanta_d;
            slot_q   <= (pause_load || quanta_q == 16'h0000 || slot_q == slot_max) ? 13'h0000 :
                        slot_q + 13'h0001;
            TX_HALT  <= quanta_d != 16'h0000;
        end
    end

    // Pause sender in full duplex, backpressure in half duplex.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FC_IDLE: begin
                if (send_q && txen_q && (fd_q || pause_decode_enable_q)) begin
                    state_d = fd_q ? FC_SEND : FC_BACKP;
                end
            end
            FC_SEND: begin
                if (TX_PAUSE_DONE) begin
                    state_d = FC_IDLE;
                end
            end
            FC_BACKP: begin
                if (!(send_q && txen_q && pause_decode_enable_q && !fd_q)) begin
                    state_d = FC_IDLE;
                end
            end
            default: state_d = FC_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_q       <= FC_IDLE;
            busy_q        <= 1'b0;
            TX_PAUSE_REQ  <= 1'b0;
            BACKPRESSURE  <= 1'b0;
            TX_PAUSE_TIME <= 16'h0000;
        end else begin
            state_q       <= state_d;
            busy_q        <= state_d != FC_IDLE;
            TX_PAUSE_REQ  <= state_d == FC_SEND;
            BACKPRESSURE  <= state_d == FC_BACKP;
            TX_PAUSE_TIME <= time_q;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    a_filter_set: assert property (pause_hit && pass_q && !promisc_q |-> ##1 RX_OUT_VALID)
        else $error("filtered pause frame did not reach the FIFO output");
    a_filter_gate: assert property (push && in_beat.filt |-> pass_q && !promisc_q && pause_decode_enable_q)
        else $error("filter flag set without pass-control or under promiscuous mode");
    a_halt_start: assert property (pause_load && rx_time != 16'h0000 |=> TX_HALT && quanta_q == $past(rx_time))
        else $error("valid pause did not halt the transmitter with its time");
    a_halt_needs_fd: assert property (!TX_HALT && (!fd_q || !pause_decode_enable_q) |=> !TX_HALT)
        else $error("transmitter halted outside enabled full duplex");
    a_no_decode_off: assert property (!pause_decode_enable_q |-> !pause_hit)
        else $error("pause decoded while flow control disabled");
    a_busy_covers: assert property ((TX_PAUSE_REQ || BACKPRESSURE) |-> busy_q)
        else $error("busy low while pause or backpressure active");
    a_busy_clears: assert property (state_q == FC_SEND && TX_PAUSE_DONE |=> !busy_q && !TX_PAUSE_REQ)
        else $error("busy did not clear after pause frame sent");
    a_time_insert: assert property (TX_PAUSE_REQ |-> TX_PAUSE_TIME == $past(time_q))
        else $error("pause frame time differs from register");
    a_txen_quiet: assert property (!txen_q && state_q != FC_SEND |=> !TX_PAUSE_REQ && !BACKPRESSURE)
        else $error("pause or backpressure while transmitter disabled");
    a_backp_hd: assert property (BACKPRESSURE |-> !$past(fd_q) && $past(pause_decode_enable_q))
        else $error("backpressure outside enabled half duplex");
    a_slot_step: assert property (quanta_q != 16'h0000 && !pause_load && slot_q != slot_max |=> $stable(quanta_q))
        else $error("pause count moved inside a slot");

    c_pause_rx: cover property (pause_load ##1 TX_HALT);
    c_pause_tx: cover property (TX_PAUSE_REQ ##[1:50] !busy_q);
    c_backp: cover property (BACKPRESSURE [*3]);
    c_fifo_full: cover property (!rx_ready && RX_IN_VALID);
endmodule

`default_nettype wire

/* File: rtl/mac_pause_pkg.sv */
// Constants, field layouts and carrier types of the MAC pause flow-control block.
// Assumes a 100 MHz system clock and word-indexed registers on a 32-bit AHB-Lite bus.
package mac_pause_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned SLOT_BITS       = 512;
    localparam int unsigned BIT_TIME_100_NS = 10;
    localparam int unsigned BIT_TIME_10_NS  = 100;
    localparam int unsigned SLOT_CYC_100    = (SLOT_BITS * BIT_TIME_100_NS) / CLK_PERIOD_NS;
    localparam int unsigned SLOT_CYC_10     = (SLOT_BITS * BIT_TIME_10_NS) / CLK_PERIOD_NS;
    localparam int unsigned RX_FIFO_DEPTH   = 8;

    // Register indexes; the byte address is four times the index.
    localparam logic [7:0] IDX_PAUSE_CTRL = 8'h08;
    localparam logic [7:0] IDX_MAC_CFG    = 8'h10;
    localparam logic [7:0] IDX_MAC_STAT   = 8'h11;

    localparam int unsigned PC_TIME_LSB      = 16;
    localparam int unsigned PC_PASS_BIT      = 2;
    localparam int unsigned PC_EN_BIT        = 1;
    localparam int unsigned PC_BUSY_BIT      = 0;
    localparam int unsigned CFG_FD_BIT       = 0;
    localparam int unsigned CFG_TXEN_BIT     = 1;
    localparam int unsigned CFG_PROMISC_BIT  = 2;
    localparam int unsigned CFG_SPEED100_BIT = 3;
    localparam int unsigned CFG_SEND_BIT     = 4;
    localparam int unsigned STAT_PAUSED_BIT  = 16;
    localparam int unsigned STAT_BACKP_BIT   = 17;

    localparam logic [31:0] PAUSE_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] MAC_CFG_RST    = 32'h0000_0000;

    localparam logic [47:0] PAUSE_DA     = 48'h0180_c200_0001;
    localparam logic [15:0] PAUSE_ETYPE  = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
    localparam logic [4:0]  POS_TYPE     = 5'h0c;
    localparam logic [4:0]  POS_TIME     = 5'h10;
    localparam logic [4:0]  POS_MIN_LAST = 5'h12;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
        logic       err;
        logic       filt;
    } rx_beat_s;

    typedef enum logic [1:0] {
        FC_IDLE  = 2'b00,
        FC_SEND  = 2'b01,
        FC_BACKP = 2'b10
    } fc_state_e;
endpackage

/* File: verification/tx_station_model.sv */
// Stand-in for the transmitter that sends pause frames for the flow-control block.
// Assumes one clock and a pause request held high until the done pulse is seen.
`timescale 1ns/1ps
`default_nettype none

module tx_station_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  delay,
    input  wire logic        pause_req,
    input  wire logic [15:0] pause_time,
    output logic             pause_done,
    output logic      [15:0] sent_time
);
    logic [7:0] cnt_q;

    // The done pulse lasts one cycle, and the count restarts once the request drops.
    always_ff @(posedge clk) begin
        if (rst || !pause_req || pause_done) begin
            cnt_q      <= 8'h00;
            pause_done <= 1'b0;
        end else if (cnt_q >= delay) begin
            pause_done <= 1'b1;
            sent_time  <= pause_time;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule

`default_nettype wire

/* File: verification/mac_pause_flow_control_tb.sv */
// Self-checking bench for the pause flow-control block and its receive FIFO.
// Assumes the transmitter stand-in model and a shortened 10 Mb/s slot length.
`timescale 1ns/1ps
`default_nettype none

module mac_pause_flow_control_tb import mac_pause_pkg::*; ();
    localparam int unsigned SLOT   = 8;
    localparam logic [31:0] A_CTRL = {22'h0, IDX_PAUSE_CTRL, 2'b00};
    localparam logic [31:0] A_CFG  = {22'h0, IDX_MAC_CFG, 2'b00};
    localparam logic [31:0] A_STAT = {22'h0, IDX_MAC_STAT, 2'b00};
    logic        SYS_CLK, RST, HSEL, HWRITE, RX_IN_VALID, RX_IN_LAST, RX_IN_ERR, RX_OUT_READY;
    logic        HREADYOUT, HRESP, RX_IN_READY, RX_OUT_VALID, RX_OUT_LAST, RX_OUT_ERR, RX_OUT_FILTER;
    logic        TX_HALT, TX_PAUSE_REQ, TX_PAUSE_DONE, BACKPRESSURE, got_filt, got_err;
    logic [31:0] HADDR, HWDATA, HRDATA, rdata;
    logic [1:0]  HTRANS;
    logic [2:0]  HSIZE;
    logic [7:0]  RX_IN_DATA, RX_OUT_DATA, dly, got_data;
    logic [15:0] TX_PAUSE_TIME, sent_time;
    logic [7:0]  cfg_t [6] = '{8'h03, 8'h03, 8'h07, 8'h03, 8'h02, 8'h03};
    logic [4:0]  row_t [6] = '{5'b01111, 5'b00101, 5'b01101, 5'b01000, 5'b01110, 5'b11100};
    wire  logic  HREADY = HREADYOUT;
    int          mismatches, num_checks, nbytes, n;

    mac_pause_flow_control #(.SLOT_CYCLES_10M(SLOT), .FIFO_DEPTH(8)) u_dut (
        .SYS_CLK(SYS_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
        .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRDATA(HRDATA),
        .HRESP(HRESP), .RX_IN_VALID(RX_IN_VALID), .RX_IN_DATA(RX_IN_DATA), .RX_IN_LAST(RX_IN_LAST),
        .RX_IN_ERR(RX_IN_ERR), .RX_IN_READY(RX_IN_READY), .RX_OUT_VALID(RX_OUT_VALID),
        .RX_OUT_DATA(RX_OUT_DATA), .RX_OUT_LAST(RX_OUT_LAST), .RX_OUT_ERR(RX_OUT_ERR),
        .RX_OUT_FILTER(RX_OUT_FILTER), .RX_OUT_READY(RX_OUT_READY), .TX_HALT(TX_HALT),
        .TX_PAUSE_REQ(TX_PAUSE_REQ), .TX_PAUSE_TIME(TX_PAUSE_TIME), .TX_PAUSE_DONE(TX_PAUSE_DONE),
        .BACKPRESSURE(BACKPRESSURE));
    tx_station_model u_tx (.clk(SYS_CLK), .rst(RST), .delay(dly), .pause_req(TX_PAUSE_REQ),
        .pause_time(TX_PAUSE_TIME), .pause_done(TX_PAUSE_DONE), .sent_time(sent_time));

    always #5 SYS_CLK = ~SYS_CLK;

    // The application side keeps the status of each frame's final byte.
    always @(posedge SYS_CLK) begin
        if (RX_OUT_VALID === 1'b1 && RX_OUT_READY === 1'b1) begin
            nbytes++;
            if (RX_OUT_LAST === 1'b1) begin
                got_filt = RX_OUT_FILTER;
                got_err  = RX_OUT_ERR;
                got_data = RX_OUT_DATA;
            end
        end
    end

    task automatic tally_and_finish();
        if (mismatches == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic bus_wait();
        int k;
        k = 0;
        do begin
            @(posedge SYS_CLK);
            k++;
        end while (HREADY !== 1'b1 && k < 50);
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        HSEL   <= 1'b1;
        HTRANS <= 2'b10;
        HADDR  <= a;
        HWRITE <= wr;
        bus_wait();
        HTRANS <= 2'b00;
        HWDATA <= wd;
        bus_wait();
        rdata = HRDATA;
        chk(HRESP, 1'b0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0000_0000);
        chk(rdata, exp);
    endtask

    task automatic rx_push(input logic [7:0] d, input logic l, input logic e);
        int k;
        k = 0;
        RX_IN_VALID <= 1'b1;
        RX_IN_DATA  <= d;
        RX_IN_LAST  <= l;
        RX_IN_ERR   <= e;
        do begin
            @(posedge SYS_CLK);
            k++;
        end while (RX_IN_READY !== 1'b1 && k < 100);
    endtask

    task automatic rx_pause(input logic [15:0] qt, input logic e);
        logic [7:0] b [19];
        b = '{8'h01, 8'h80, 8'hc2, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h05,
              8'h88, 8'h08, 8'h00, 8'h01, qt[15:8], qt[7:0], 8'h00};
        for (int i = 0; i < 19; i++) begin
            rx_push(b[i], i == 18, e);
        end
        RX_IN_VALID <= 1'b0;
    endtask

    task automatic wait_req(input logic v);
        int k;
        k = 0;
        while (TX_PAUSE_REQ !== v && k < 60) begin
            @(posedge SYS_CLK);
            k++;
        end
    endtask

    initial begin
        {SYS_CLK, HSEL, HWRITE, RX_IN_VALID, RX_IN_LAST, RX_IN_ERR} = '0;
        {HADDR, HWDATA, HTRANS, RX_IN_DATA, mismatches, num_checks, nbytes} = '0;
        RST = 1'b1;
        RX_OUT_READY = 1'b1;
        HSIZE = 3'b010;
        dly = 8'h14;
        repeat (12) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        rd(A_CTRL, 32'h0000_0000);
        rd(A_CFG, 32'h0000_0000);
        wr(32'h0000_0400, 32'hffff_ffff);
        rd(32'h0000_0400, 32'h0000_0000);
        wr(A_CTRL, 32'h1234_0006);
        rd(A_CTRL, 32'h1234_0006);
        // Fill the FIFO with the drain stalled, then finish an errored frame.
        RX_OUT_READY <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rx_push(i[7:0], 1'b0, 1'b0);
        end
        RX_IN_VALID <= 1'b0;
        @(posedge SYS_CLK);
        chk(RX_IN_READY, 1'b0);
        RX_OUT_READY <= 1'b1;
        rx_push(8'h08, 1'b1, 1'b1);
        RX_IN_VALID <= 1'b0;
        repeat (12) @(posedge SYS_CLK);
        chk(nbytes, 9);
        chk(got_err, 1'b1);
        chk(got_data, 8'h08);
        // Each row holds error, pass-control, decode enable, expected filter flag and expected halt.
        for (int i = 0; i < 6; i++) begin
            wr(A_CFG, {24'h0, cfg_t[i]});
            wr(A_CTRL, {29'h0, row_t[i][3:2], 1'b0});
            rx_pause(16'h0003, row_t[i][4]);
            repeat (3) @(posedge SYS_CLK);
            chk(got_filt, row_t[i][1]);
            chk(TX_HALT, row_t[i][0]);
            if (i == 0) rd(A_STAT, 32'h0001_0003);
            n = 0;
            while (TX_HALT === 1'b1 && n < 400) begin
                @(posedge SYS_CLK);
                n++;
            end
            if (row_t[i][0]) chk(n >= 2 * SLOT - 2 && n <= 3 * SLOT + 2, 1'b1);
        end
        wr(A_CTRL, 32'habcd_0002);
        for (int k = 0; k < 2; k++) begin
            dly <= (k == 0) ? 8'h14 : 8'h01;
            wr(A_CFG, 32'h0000_0013);
            wait_req(1'b1);
            chk(TX_PAUSE_TIME, 16'habcd);
            if (k == 0) rd(A_CTRL, 32'habcd_0003);
            wait_req(1'b0);
            chk(sent_time, 16'habcd);
            rd(A_CTRL, 32'habcd_0002);
            rd(A_CFG, 32'h0000_0003);
        end
        wr(A_CFG, 32'h0000_0011);
        repeat (20) @(posedge SYS_CLK);
        chk(TX_PAUSE_REQ, 1'b0);
        wr(A_CFG, 32'h0000_0010);
        repeat (20) @(posedge SYS_CLK);
        chk(BACKPRESSURE, 1'b0);
        wr(A_CFG, 32'h0000_0012);
        repeat (3) @(posedge SYS_CLK);
        chk(BACKPRESSURE, 1'b1);
        rd(A_CTRL, 32'habcd_0003);
        wr(A_CFG, 32'h0000_0002);
        repeat (3) @(posedge SYS_CLK);
        chk(BACKPRESSURE, 1'b0);
        rd(A_CTRL, 32'habcd_0002);
        wr(A_CTRL, 32'habcd_0000);
        wr(A_CFG, 32'h0000_0012);
        repeat (5) @(posedge SYS_CLK);
        chk(BACKPRESSURE, 1'b0);
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge SYS_CLK);
        mismatches++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
